// ===== design/etfg_pkg.sv
// Package for the extension timing select and fg/bg control register bank.
// Assumes a classic Wishbone slave with 32-bit data, lane 0 only except the status unlock flag at bit 8, one register per address.
package etfg_pkg;
    localparam logic [7:0] ETFG_OFF_UNLOCK = 8'h18;
    localparam logic [7:0] ETFG_OFF_FG_COLOR = 8'h1c;
    localparam logic [7:0] ETFG_OFF_BG_COLOR = 8'h20;
    localparam logic [7:0] ETFG_OFF_PATTERN = 8'h24;
    localparam logic [7:0] ETFG_OFF_LATCH0 = 8'h28;
    localparam logic [7:0] ETFG_OFF_CTRL = 8'h38;
    localparam logic [7:0] ETFG_OFF_STATUS = 8'h3c;
    localparam logic [7:0] ETFG_OFF_TIMING = 8'hfd;
    localparam logic [7:0] ETFG_OFF_FGBG = 8'hfe;
    localparam logic [7:0] ETFG_UNLOCK_KEY = 8'hea;
    localparam logic [7:0] ETFG_TIMING_RST = 8'h00;
    localparam logic [1:0] ETFG_MODE_RST = 2'h0;
    localparam int ETFG_GFX_LSB = 4;
    localparam int ETFG_TXT_LSB = 0;
    localparam int ETFG_MODE_LSB = 2;
    localparam int ETFG_SRC_BIT = 1;
    localparam int ETFG_CTRL_CHAR8_BIT = 0;
    localparam int ETFG_CTRL_GFX_BIT = 1;
    localparam int ETFG_CTRL_SRST_BIT = 2;

    typedef enum logic [6:0] {
        ETFG_TS_INVALID = 7'h01,
        ETFG_TS_D14 = 7'h02,
        ETFG_TS_D12 = 7'h04,
        ETFG_TS_DP14 = 7'h08,
        ETFG_TS_V11 = 7'h10,
        ETFG_TS_V12 = 7'h20,
        ETFG_TS_V14 = 7'h40
    } etfg_ts_e;

    typedef enum logic [1:0] {
        ETFG_FGBG_SETRESET = 2'h0,
        ETFG_FGBG_SOLID = 2'h1,
        ETFG_FGBG_DITHER = 2'h2,
        ETFG_FGBG_BAD = 2'h3
    } etfg_fgbg_e;

    // Bus slave states, one-hot
    typedef enum logic [1:0] {
        ETFG_BUS_IDLE = 2'h1,
        ETFG_BUS_ACK = 2'h2
    } etfg_bus_e;
endpackage : etfg_pkg

// ===== design/etfg_timing_decode.sv
// Decodes a 4-bit timing code into a timing state, RAM type and ratio.
// Assumes the caller has already chosen the field for the current mode.
`timescale 1ns/1ps
module etfg_timing_decode (
    input wire logic [3:0] code,
    input wire logic gfx,
    input wire logic char8,
    output etfg_pkg::etfg_ts_e state,
    output logic vram,
    output logic [1:0] cpu_n,
    output logic [2:0] char_m,
    output logic paged
);
    always_comb
    begin
        state = etfg_pkg::ETFG_TS_INVALID;
        if (!char8)
        begin
            state = etfg_pkg::ETFG_TS_D14;
        end
        else if (gfx)
        begin
            case (code)
                4'h0: state = etfg_pkg::ETFG_TS_D14;
                4'h2: state = etfg_pkg::ETFG_TS_D12;
                4'h3: state = etfg_pkg::ETFG_TS_DP14;
                4'h8: state = etfg_pkg::ETFG_TS_V11;
                4'h9: state = etfg_pkg::ETFG_TS_V12;
                4'ha: state = etfg_pkg::ETFG_TS_V14;
                default: state = etfg_pkg::ETFG_TS_INVALID;
            endcase
        end
        else
        begin
            case (code)
                4'h0: state = etfg_pkg::ETFG_TS_D14;
                4'h2: state = etfg_pkg::ETFG_TS_D12;
                4'ha: state = etfg_pkg::ETFG_TS_V14;
                default: state = etfg_pkg::ETFG_TS_INVALID;
            endcase
        end
    end

    // Ratio n:m, n CPU accesses per m character clocks
    always_comb
    begin
        vram = 1'b0;
        cpu_n = 2'h1;
        char_m = 3'h4;
        paged = 1'b0;
        case (state)
            etfg_pkg::ETFG_TS_D12: char_m = 3'h2;
            etfg_pkg::ETFG_TS_DP14: paged = 1'b1;
            etfg_pkg::ETFG_TS_V11:
            begin
                vram = 1'b1;
                char_m = 3'h1;
            end
            etfg_pkg::ETFG_TS_V12:
            begin
                vram = 1'b1;
                char_m = 3'h2;
            end
            etfg_pkg::ETFG_TS_V14: vram = 1'b1;
            etfg_pkg::ETFG_TS_INVALID:
            begin
                cpu_n = 2'h0;
                char_m = 3'h0;
            end
            default: char_m = 3'h4;
        endcase
    end
endmodule : etfg_timing_decode

// ===== design/etfg_regs.sv
// Extension timing select and fg/bg control bank with the plane ALU input mux.
// Assumes classic Wishbone, synchronous inputs, one ref_clk domain.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module etfg_regs #(
    parameter int PLANES = 4
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [PLANES*8-1:0] setreset_out,
    input wire logic [7:0] rotated_cpu_byte,
    output logic [PLANES*8-1:0] alu_cpu_in,
    output logic [6:0] timing_state,
    output logic ram_is_vram,
    output logic [1:0] cpu_accesses,
    output logic [2:0] char_clocks,
    output logic paged_fetch,
    output logic [2:0] start_addr_step,
    output logic [1:0] row_offset_step,
    output logic seq_hold_reset
);
    // Color registers hold one bit per plane, so only four planes fit
    generate
        if (PLANES != 4)
        begin : g_bad_planes
            $error("PLANES must be 4");
        end
    endgenerate

    typedef struct packed {
        etfg_pkg::etfg_bus_e bus;
        logic [31:0] rdata;
        logic [7:0] unlock;
        logic [7:0] timing;
        logic [1:0] mode;
        logic src;
        logic [3:0] fg_color;
        logic [3:0] bg_color;
        logic [7:0] pattern;
        logic [PLANES*8-1:0] latches;
        logic [2:0] ctrl;
        logic [PLANES*8-1:0] alu;
    } etfg_state_s;

    etfg_state_s st_r;
    etfg_state_s st_nxt;
    etfg_pkg::etfg_ts_e ts;
    logic [3:0] code;
    logic unlocked;
    logic [7:0] selb;
    logic [PLANES*8-1:0] solid;
    logic [PLANES*8-1:0] dither;

    assign unlocked = (st_r.unlock == etfg_pkg::ETFG_UNLOCK_KEY);
    assign selb = st_r.src ? rotated_cpu_byte : st_r.pattern;
    assign code = st_r.ctrl[etfg_pkg::ETFG_CTRL_GFX_BIT]
        ? st_r.timing[etfg_pkg::ETFG_GFX_LSB +: 4]
        : st_r.timing[etfg_pkg::ETFG_TXT_LSB +: 4];

    genvar p;
    generate
        for (p = 0; p < PLANES; p++)
        begin : g_plane
            // Foreground bit of this plane on pixels set in selb, background bit on the other pixels of the byte
            assign solid[p*8 +: 8] = (selb & {8{st_r.fg_color[p]}})
                | (~selb & {8{st_r.bg_color[p]}});
            assign dither[p*8 +: 8] = st_r.latches[p*8 +: 8];
        end
    endgenerate

    etfg_timing_decode u_dec (
        .code(code),
        .gfx(st_r.ctrl[etfg_pkg::ETFG_CTRL_GFX_BIT]),
        .char8(st_r.ctrl[etfg_pkg::ETFG_CTRL_CHAR8_BIT]),
        .state(ts),
        .vram(ram_is_vram),
        .cpu_n(cpu_accesses),
        .char_m(char_clocks),
        .paged(paged_fetch)
    );

    always_comb
    begin
        st_nxt = st_r;
        case (st_r.bus)
            etfg_pkg::ETFG_BUS_IDLE:
            begin
                // Read data is captured here and stands through the ack cycle
                if (wb_cyc_i && wb_stb_i)
                begin
                    st_nxt.bus = etfg_pkg::ETFG_BUS_ACK;
                    st_nxt.rdata = 32'h0000_0000;
                    if (wb_adr_i == etfg_pkg::ETFG_OFF_UNLOCK)
                        st_nxt.rdata[7:0] = st_r.unlock;
                    else if (wb_adr_i == etfg_pkg::ETFG_OFF_FG_COLOR)
                        st_nxt.rdata[3:0] = st_r.fg_color;
                    else if (wb_adr_i == etfg_pkg::ETFG_OFF_BG_COLOR)
                        st_nxt.rdata[3:0] = st_r.bg_color;
                    else if (wb_adr_i == etfg_pkg::ETFG_OFF_PATTERN)
                        st_nxt.rdata[7:0] = st_r.pattern;
                    else if (wb_adr_i >= etfg_pkg::ETFG_OFF_LATCH0
                        && wb_adr_i < etfg_pkg::ETFG_OFF_CTRL)
                    begin
                        // Four latch words at 0x28..0x34
                        for (int i = 0; i < PLANES; i++)
                        begin
                            if (wb_adr_i == etfg_pkg::ETFG_OFF_LATCH0 + 8'(4 * i))
                                st_nxt.rdata[7:0] = st_r.latches[i*8 +: 8];
                        end
                    end
                    else if (wb_adr_i == etfg_pkg::ETFG_OFF_CTRL)
                        st_nxt.rdata[2:0] = st_r.ctrl;
                    else if (wb_adr_i == etfg_pkg::ETFG_OFF_STATUS)
                    begin
                        st_nxt.rdata[6:0] = ts;
                        st_nxt.rdata[8] = unlocked;
                    end
                    else if (wb_adr_i == etfg_pkg::ETFG_OFF_TIMING && unlocked)
                        st_nxt.rdata[7:0] = st_r.timing;
                    else if (wb_adr_i == etfg_pkg::ETFG_OFF_FGBG && unlocked)
                    begin
                        st_nxt.rdata[3:2] = st_r.mode;
                        st_nxt.rdata[1] = st_r.src;
                    end
                end
            end
            etfg_pkg::ETFG_BUS_ACK:
            begin
                st_nxt.bus = etfg_pkg::ETFG_BUS_IDLE;
                // Writes land on the edge where the master sees ack, never a cycle early
                if (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0])
                begin
                    if (wb_adr_i == etfg_pkg::ETFG_OFF_UNLOCK)
                        st_nxt.unlock = wb_dat_i[7:0];
                    else if (wb_adr_i == etfg_pkg::ETFG_OFF_FG_COLOR)
                        st_nxt.fg_color = wb_dat_i[3:0];
                    else if (wb_adr_i == etfg_pkg::ETFG_OFF_BG_COLOR)
                        st_nxt.bg_color = wb_dat_i[3:0];
                    else if (wb_adr_i == etfg_pkg::ETFG_OFF_PATTERN)
                        st_nxt.pattern = wb_dat_i[7:0];
                    else if (wb_adr_i >= etfg_pkg::ETFG_OFF_LATCH0
                        && wb_adr_i < etfg_pkg::ETFG_OFF_CTRL)
                    begin
                        for (int i = 0; i < PLANES; i++)
                        begin
                            if (wb_adr_i == etfg_pkg::ETFG_OFF_LATCH0 + 8'(4 * i))
                                st_nxt.latches[i*8 +: 8] = wb_dat_i[7:0];
                        end
                    end
                    else if (wb_adr_i == etfg_pkg::ETFG_OFF_CTRL)
                        st_nxt.ctrl = wb_dat_i[2:0];
                    else if (wb_adr_i == etfg_pkg::ETFG_OFF_TIMING && unlocked)
                        st_nxt.timing = wb_dat_i[7:0];
                    else if (wb_adr_i == etfg_pkg::ETFG_OFF_FGBG && unlocked)
                    begin
                        st_nxt.mode = wb_dat_i[etfg_pkg::ETFG_MODE_LSB +: 2];
                        st_nxt.src = wb_dat_i[etfg_pkg::ETFG_SRC_BIT];
                    end
                end
            end
            default:
                st_nxt.bus = etfg_pkg::ETFG_BUS_IDLE;
        endcase

        case (etfg_pkg::etfg_fgbg_e'(st_r.mode))
            etfg_pkg::ETFG_FGBG_SETRESET: st_nxt.alu = setreset_out;
            etfg_pkg::ETFG_FGBG_SOLID: st_nxt.alu = solid;
            etfg_pkg::ETFG_FGBG_DITHER: st_nxt.alu = dither;
            default: st_nxt.alu = setreset_out; // Invalid code, any choice is fine
        endcase

        if (sys_rst)
        begin
            st_nxt.bus = etfg_pkg::ETFG_BUS_IDLE;
            st_nxt.rdata = 32'h0000_0000;
            st_nxt.unlock = 8'h00;
            st_nxt.timing = etfg_pkg::ETFG_TIMING_RST;
            st_nxt.mode = etfg_pkg::ETFG_MODE_RST;
            st_nxt.ctrl = 3'h0;
            st_nxt.alu = '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        st_r <= st_nxt;
    end

    assign wb_ack_o = (st_r.bus == etfg_pkg::ETFG_BUS_ACK);
    assign wb_dat_o = st_r.rdata;
    assign alu_cpu_in = st_r.alu;
    assign timing_state = ts;
    // Paged state steps panning coarser
    assign start_addr_step = paged_fetch ? 3'h4 : 3'h1;
    assign row_offset_step = paged_fetch ? 2'h2 : 2'h1;
    // Software drives this while changing the active field
    assign seq_hold_reset = st_r.ctrl[etfg_pkg::ETFG_CTRL_SRST_BIT];
endmodule : etfg_regs

// ===== tb/etfg_regs_monitor.sv
// Port-level checker for the timing select and fg/bg bank.
// Assumes a bind from the bench top, one clock and a synchronous reset.
`timescale 1ns/1ps
module etfg_regs_monitor (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [6:0] timing_state,
    input wire logic ram_is_vram,
    input wire logic [1:0] cpu_accesses,
    input wire logic [2:0] char_clocks,
    input wire logic paged_fetch,
    input wire logic [2:0] start_addr_step,
    input wire logic [1:0] row_offset_step
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    paged_step_a: assert property (
        paged_fetch |-> start_addr_step == 3'h4 && row_offset_step == 2'h2)
        else $error("paged steps wrong");
    unpaged_step_a: assert property (
        !paged_fetch |-> start_addr_step == 3'h1 && row_offset_step == 2'h1)
        else $error("unpaged steps wrong");
    paged_state_a: assert property (paged_fetch == (timing_state == 7'h08))
        else $error("paged flag disagrees with state");
    vram_type_a: assert property (
        timing_state != 7'h01
        |-> ram_is_vram == (timing_state inside {7'h10, 7'h20, 7'h40}))
        else $error("ram type disagrees with state");
    quarter_ratio_a: assert property (
        timing_state inside {7'h02, 7'h08, 7'h40}
        |-> cpu_accesses == 2'h1 && char_clocks == 3'h4)
        else $error("ratio not 1:4");
    half_ratio_a: assert property (
        timing_state inside {7'h04, 7'h20}
        |-> cpu_accesses == 2'h1 && char_clocks == 3'h2)
        else $error("ratio not 1:2");
    reset_clear_a: assert property (
        @(posedge ref_clk) $fell(sys_rst) |-> timing_state == 7'h02 && !wb_ack_o)
        else $error("state after reset wrong");
    ack_latency_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("no answer one cycle after request");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("answer longer than one cycle");
    fgbg_zero_a: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == 8'hfe
        |-> wb_dat_o[31:4] == 28'h0 && !wb_dat_o[0])
        else $error("unused fg/bg bits not zero");
endmodule : etfg_regs_monitor

// ===== tb/etfg_regs_tb.sv
// Self-checking bench for the timing select and fg/bg bank.
// Assumes the designer's map and a one-cycle Wishbone answer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module etfg_regs_tb;
    logic ref_clk = 0;
    logic sys_rst = 1;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, ram_is_vram, paged_fetch, hold;
    logic [7:0] wb_adr_i = 0, rotated_cpu_byte = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, setreset_out = 0, wb_dat_o, alu_cpu_in, rd;
    logic [6:0] timing_state;
    logic [1:0] cpu_accesses, row_offset_step;
    logic [2:0] char_clocks, start_addr_step;
    int n_mismatch = 0, num_checks = 0;
    always #12.5 ref_clk = ~ref_clk;
    etfg_regs #(.PLANES(4)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .setreset_out(setreset_out), .rotated_cpu_byte(rotated_cpu_byte),
        .alu_cpu_in(alu_cpu_in), .timing_state(timing_state), .ram_is_vram(ram_is_vram),
        .cpu_accesses(cpu_accesses), .char_clocks(char_clocks), .paged_fetch(paged_fetch),
        .start_addr_step(start_addr_step), .row_offset_step(row_offset_step),
        .seq_hold_reset(hold));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    // Holds the request until ack is seen; a lost answer counts as a mismatch
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'h1);
        int n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        `CHK("ack", 1'b1, wb_ack_o)
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
    endtask : do_reset
    // Zero marks a code whose effect is left undefined
    function automatic logic [6:0] exp_state(input logic g, input logic [3:0] c);
        case (c)
            4'h0: return 7'h02;
            4'h2: return 7'h04;
            4'h3: return g ? 7'h08 : 7'h00;
            4'h8: return g ? 7'h10 : 7'h00;
            4'h9: return g ? 7'h20 : 7'h00;
            4'ha: return 7'h40;
            default: return 7'h00;
        endcase
    endfunction : exp_state
    function automatic logic [31:0] exp_alu(input logic [1:0] m, input logic [3:0] fg,
        input logic [3:0] bg, input logic [7:0] sel, input logic [31:0] lat);
        logic [31:0] r;
        for (int p = 0; p < 4; p++)
            r[8*p +: 8] = (sel & {8{fg[p]}}) | (~sel & {8{bg[p]}});
        return m == 2'h0 ? setreset_out : (m == 2'h1 ? r : lat);
    endfunction : exp_alu
    initial
    begin
        logic [7:0] t, w, pat, sb;
        logic [3:0] fg, bg;
        logic [1:0] m;
        logic [6:0] e;
        logic [31:0] lat, x;
        rd = $urandom(72425);
        do_reset();
        setreset_out <= $urandom;
        repeat (2) @(posedge ref_clk);
        `CHK("state_rst", 7'h02, timing_state)
        `CHK("alu_rst", setreset_out, alu_cpu_in)
        wb(1, 8'h18, 32'heb);
        wb(1, 8'hfd, 32'ha5);
        wb(1, 8'h18, 32'hea);
        wb(0, 8'hfd, 0);
        `CHK("locked_tim", 32'h0, rd)
        wb(0, 8'hfe, 0);
        `CHK("mode_rst", 2'h0, rd[3:2])
        wb(0, 8'h80, 0);
        `CHK("unmapped", 32'h0, rd)
        wb(1, 8'hfd, 32'h3c, 4'h0);
        wb(0, 8'hfd, 0);
        `CHK("sel_off", 32'h0, rd)
        for (int i = 0; i < 16; i++)
        begin
            t = {i[3:0], i[3:0] ^ 4'ha};
            wb(1, 8'h38, 32'h4);
            @(posedge ref_clk);
            `CHK("hold_on", 1'b1, hold)
            wb(1, 8'hfd, {24'h0, t});
            wb(0, 8'hfd, 0);
            `CHK("tim_rw", {24'h0, t}, rd)
            for (int c = 0; c < 3; c++)
            begin
                wb(1, 8'h38, c == 2 ? 32'h3 : 32'(c));
                @(posedge ref_clk);
                `CHK("hold_off", 1'b0, hold)
                e = c == 0 ? 7'h02 : exp_state(c == 2, c == 2 ? t[7:4] : t[3:0]);
                x = e == 7'h08 ? 32'h12 : 32'h05;
                // Undefined codes are left unchecked
                if (e != 7'h00)
                begin
                    `CHK("state", e, timing_state)
                    `CHK("steps", x[4:0], {start_addr_step, row_offset_step})
                end
            end
        end
        for (int k = 0; k < 12; k++)
        begin
            fg = $urandom;
            bg = $urandom;
            pat = $urandom;
            lat = $urandom;
            t = $urandom;
            m = 2'(k % 3);
            w = {t[7:4], m, t[1:0]};
            wb(1, 8'h1c, {28'h0, fg});
            wb(1, 8'h20, {28'h0, bg});
            wb(1, 8'h24, {24'h0, pat});
            for (int p = 0; p < 4; p++)
                wb(1, 8'(8'h28 + 4 * p), {24'h0, lat[8*p +: 8]});
            wb(1, 8'hfe, {24'h0, w});
            wb(0, 8'hfe, 0);
            `CHK("fgbg_rw", {24'h0, w & 8'h0e}, rd)
            setreset_out <= $urandom;
            rotated_cpu_byte <= $urandom;
            repeat (3) @(posedge ref_clk);
            sb = w[1] ? rotated_cpu_byte : pat;
            x = exp_alu(m, fg, bg, sb, lat);
            `CHK("alu", x, alu_cpu_in)
        end
        wb(1, 8'h38, 32'h4);
        wb(1, 8'hfd, 32'h5a);
        wb(1, 8'h18, 32'h00);
        wb(0, 8'hfd, 0);
        `CHK("locked_rd", 32'h0, rd)
        wb(0, 8'hfe, 0);
        `CHK("locked_fgbg", 32'h0, rd)
        do_reset();
        wb(1, 8'h18, 32'hea);
        wb(0, 8'hfd, 0);
        `CHK("tim_rerst", 32'h0, rd)
        wb(0, 8'hfe, 0);
        `CHK("mode_rerst", 2'h0, rd[3:2])
        print_verdict();
    end
    // Generous bound: the sequence needs well under half of it
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        print_verdict();
    end
endmodule : etfg_regs_tb
bind etfg_regs etfg_regs_monitor mon (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timing_state(timing_state), .ram_is_vram(ram_is_vram),
    .cpu_accesses(cpu_accesses), .char_clocks(char_clocks), .paged_fetch(paged_fetch),
    .start_addr_step(start_addr_step), .row_offset_step(row_offset_step));
